// ---- hw/qdu_top.sv ----
// quad dac update control: frame decode, code registers, updates, resets, alarm
module qdu_top
   import qdu_pkg::*;
#(
   parameter int POR_CYC = POR_WAIT_CYC // reinit busy time, shortened in simulation
) (
   input  wire logic        clk_i,          // core clock, 20 MHz
   input  wire logic        rst_n_i,        // synchronous reset, active low
   input  wire logic        supply_ok_i,    // supplies valid level
   input  wire logic        reset_pin_n_i,  // hardware reset pin
   input  wire logic        sclk_i,         // serial clock pin
   input  wire logic        sel_n_i,        // frame strobe pin
   input  wire logic        serial_in_i,    // serial data in
   input  wire logic        load_pin_n_i,   // load trigger pin
   input  wire logic        clear_pin_n_i,  // clear pin
   input  wire logic        overtemp_i,     // die above 140 C
   output logic             serial_out_o,   // serial data out
   output logic             serial_out_oe_o,// serial out drive enable
   output logic [63:0]      active_code_o,  // four active codes, channel 0 low
   output logic [3:0]       chan_on_o,      // amplifier enabled per channel
   output logic             ref_on_o,       // internal reference powered
   output logic             fault_n_o,      // fault pin, low on alarm
   output logic             busy_o          // reinit in progress
);
   logic        sup_s;          // supplies valid, synchronised
   logic        rstp_s;         // reset pin, synchronised
   logic        sclk_s;         // serial clock, synchronised
   logic        sel_s;          // frame strobe, synchronised
   logic        din_s;          // serial_in, synchronised
   logic        load_s;         // load pin, synchronised
   logic        clr_s;          // clear pin, synchronised
   logic        hot_s;          // overtemp level, synchronised
   logic        load_d;         // load pin one cycle back
   qdu_cmd_s    cmd;
   logic        cmd_vld;
   logic        so;
   logic [23:0] reply;
   logic [15:0] spicfg;
   logic [15:0] gencfg;
   logic [15:0] range;
   logic [3:0]  common_en;
   logic [3:0]  sync_en;
   logic [3:0]  pwdn;
   logic [15:0] buf_code [NCHAN];
   logic [15:0] act_code [NCHAN];
   logic        overtemp_flag;
   logic [5:0]  rst_cnt;
   logic [31:0] por_cnt;
   logic        por;
   logic        por_supply;
   logic        por_pin;
   logic        por_soft;
   logic        wr;
   logic        soft_load_trigger;
   logic        soft_clear_cmd;
   logic        alarm_clear_cmd;
   logic        trigger;
   logic        clear;
   logic [15:0] rd_data;

   // true when an accepted write targets the trigger register
   function automatic logic trg_write(input qdu_cmd_s k, input logic w);
      return w && k.addr == A_TRIGGER;
   endfunction

   // channel c takes a code write directly or through the common value
   function automatic logic chan_hit(input qdu_cmd_s k, input logic [3:0] en, input int c);
      return k.addr == A_CHAN0 + 6'(c) || (k.addr == A_COMMON && en[c]);
   endfunction

   // every pin passes two flops before any logic reads it
   // supply level; resets low so a fresh release always starts one reinit
   qdu_sync2 #(.RST_VAL(1'b0)) u_sup (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (supply_ok_i),
      .q_o     (sup_s)
   );

   // reset pin idles high
   qdu_sync2 #(.RST_VAL(1'b1)) u_rstp (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (reset_pin_n_i),
      .q_o     (rstp_s)
   );

   // serial clock; any edge after reset is harmless while the strobe is high
   qdu_sync2 #(.RST_VAL(1'b0)) u_sclk (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (sclk_i),
      .q_o     (sclk_s)
   );

   // frame strobe idles high
   qdu_sync2 #(.RST_VAL(1'b1)) u_sel (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (sel_n_i),
      .q_o     (sel_s)
   );

   // data shares the clock's latency so sampling stays aligned
   qdu_sync2 #(.RST_VAL(1'b0)) u_din (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (serial_in_i),
      .q_o     (din_s)
   );

   // load pin idles high so reset leaves no false fall
   qdu_sync2 #(.RST_VAL(1'b1)) u_load (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (load_pin_n_i),
      .q_o     (load_s)
   );

   // clear pin idles high
   qdu_sync2 #(.RST_VAL(1'b1)) u_clr (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (clear_pin_n_i),
      .q_o     (clr_s)
   );

   // temperature sensor level
   qdu_sync2 #(.RST_VAL(1'b0)) u_hot (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (overtemp_i),
      .q_o     (hot_s)
   );

   qdu_link u_link (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .sclk_s_i     (sclk_s),
      .sel_n_s_i    (sel_s),
      .din_s_i      (din_s),
      .long_frame_i (spicfg[CFG_LONG_FRAME]),
      .edge_sel_i   (spicfg[CFG_EDGE_SEL]),
      .reply_i      (reply),
      .cmd_o        (cmd),
      .cmd_vld_o    (cmd_vld),
      .so_o         (so)
   );

   // load pin edge history
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         load_d <= 1'b1;
      end else begin
         load_d <= load_s;
      end
   end

   // reset pin low time; one core cycle covers 50 ns so any seen low counts
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || rstp_s) begin
         rst_cnt <= 6'h0;
      end else if (rst_cnt < 6'(RST_LOW_CYC)) begin
         rst_cnt <= rst_cnt + 6'h1;
      end
   end

   // writes act only after the command has crossed; busy blocks them
   assign wr = cmd_vld && !cmd.read && !busy_o;
   assign soft_load_trigger = trg_write(cmd, wr) && cmd.data[TRG_LOAD];
   assign soft_clear_cmd    = trg_write(cmd, wr) && cmd.data[TRG_CLEAR];
   assign alarm_clear_cmd   = trg_write(cmd, wr) && cmd.data[TRG_ALARM_CLR];
   assign trigger = soft_load_trigger || (load_d && !load_s);
   assign clear   = soft_clear_cmd || !clr_s;

   // power-on reset sources; a supply drop holds the request, the pin fires once per pulse
   assign por_supply = !sup_s;
   assign por_pin    = !rstp_s && rst_cnt == 6'(RST_LOW_CYC - 1);
   assign por_soft   = trg_write(cmd, wr) && cmd.data == SOFT_RESET_WORD;
   assign por        = por_supply || por_pin || por_soft;

   // busy counter models the reinit delay that the host must respect
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || por) begin
         por_cnt <= 32'(POR_CYC);
         busy_o  <= 1'b1;
      end else if (por_cnt != 32'h0) begin
         por_cnt <= por_cnt - 32'h1;
         busy_o  <= por_cnt != 32'h1;
      end else begin
         busy_o  <= 1'b0;
      end
   end

   // configuration registers; defaults leave everything powered down
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || por) begin
         spicfg    <= RST_SPICFG;
         gencfg    <= RST_GENCFG;
         common_en <= RST_COMMONEN;
         sync_en   <= RST_SYNCEN;
         pwdn      <= RST_PWDN;
         range     <= RST_RANGE;
      end else if (wr) begin
         case (cmd.addr)
            A_SPICFG:   spicfg    <= cmd.data;
            A_GENCFG:   gencfg    <= cmd.data;
            A_COMMONEN: common_en <= cmd.data[3:0];
            A_SYNCEN:   sync_en   <= cmd.data[3:0];
            A_PWDN:     pwdn      <= cmd.data[3:0];
            A_RANGE:    range     <= cmd.data;
            default:    ;
         endcase
      end
   end

   // buffer and active code per channel; clear beats every write
   always_ff @(posedge clk_i) begin
      for (int c = 0; c < NCHAN; c++) begin
         if (!rst_n_i || por) begin
            buf_code[c] <= CODE_ZERO;
            act_code[c] <= CODE_ZERO;
         end else if (clear) begin
            buf_code[c] <= qdu_clear_code(range[4*c +: 4]);
            act_code[c] <= qdu_clear_code(range[4*c +: 4]);
         end else if (wr && chan_hit(cmd, common_en, c)) begin
            buf_code[c] <= cmd.data;
            if (!sync_en[c]) begin
               act_code[c] <= cmd.data;
            end else if (trigger) begin
               act_code[c] <= buf_code[c];
            end
         end else if (sync_en[c] && trigger) begin
            act_code[c] <= buf_code[c];
         end
      end
   end

   // overtemp latches and holds until cleared while powered down and cool
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || por) begin
         overtemp_flag <= 1'b0;
      end else if (hot_s) begin
         overtemp_flag <= 1'b1;
      end else if (alarm_clear_cmd && (&pwdn || spicfg[CFG_SLEEP])) begin
         overtemp_flag <= 1'b0;
      end
   end

   // output drive state; codes are kept while powered down
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || por) begin
         chan_on_o     <= 4'h0;
         ref_on_o      <= 1'b0;
         fault_n_o     <= 1'b1;
      end else begin
         for (int c = 0; c < NCHAN; c++) begin
            chan_on_o[c] <= !pwdn[c] && !spicfg[CFG_SLEEP] && !overtemp_flag;
         end
         ref_on_o  <= !spicfg[CFG_SLEEP] || overtemp_flag;
         fault_n_o <= !(overtemp_flag && spicfg[CFG_OVERTEMP_EN]);
      end
   end

   // active codes to the converters; outputs follow the active registers one cycle later
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || por) begin
         active_code_o <= 64'h0;
      end else begin
         for (int c = 0; c < NCHAN; c++) begin
            active_code_o[16*c +: 16] <= act_code[c];
         end
      end
   end

   // readback mux
   always_comb begin
      rd_data = 16'h0;
      case (cmd.addr)
         A_DEVID:    rd_data = DEVICE_ID;
         A_STATUS:   rd_data = {15'h0, overtemp_flag};
         A_SPICFG:   rd_data = spicfg;
         A_GENCFG:   rd_data = gencfg;
         A_COMMONEN: rd_data = {12'h0, common_en};
         A_SYNCEN:   rd_data = {12'h0, sync_en};
         A_PWDN:     rd_data = {12'h0, pwdn};
         default:    rd_data = 16'h0;
      endcase
   end

   // reply word captured at the end of each accepted frame
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || por) begin
         reply <= 24'h0;
      end else if (cmd_vld) begin
         reply <= {cmd.read, 1'b0, cmd.addr, cmd.read ? rd_data : 16'h0};
      end
   end

   // serial bit retimed so the pin comes straight from a flop
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         serial_out_o <= 1'b0;
      end else begin
         serial_out_o <= so;
      end
   end

   // serial output is driven only inside a frame and only when enabled
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         serial_out_oe_o <= 1'b0;
      end else begin
         serial_out_oe_o <= !sel_s && spicfg[CFG_SO_EN];
      end
   end
endmodule

// ---- hw/qdu_pkg.sv ----
// package: constants, types and helpers for the quad dac update control block
package qdu_pkg;
   localparam int FRAME_SHORT  = 24;         // frame length, error checking off
   localparam int FRAME_LONG   = 32;         // frame length, error checking on
   localparam int CLK_MHZ      = 20;         // core clock rate
   localparam int UPD_WAIT_NS  = 2400;       // least spacing of output updates, 2.4 us
   localparam int UPD_WAIT_CYC = (UPD_WAIT_NS * CLK_MHZ + 999) / 1000;
   localparam int POR_WAIT_US  = 1000;       // 1 ms reinit delay
   localparam int POR_WAIT_CYC = POR_WAIT_US * CLK_MHZ;
   localparam int RST_LOW_NS   = 20;         // least reset pin low time
   localparam int RST_LOW_CYC  = (RST_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int NCHAN        = 4;

   // frame field positions
   localparam int BIT_READ     = 23;
   localparam int ADDR_HI      = 21;
   localparam int ADDR_LO      = 16;
   localparam int DATA_HI      = 15;

   // register addresses
   localparam logic [5:0] A_NOP      = 6'h00;
   localparam logic [5:0] A_DEVID    = 6'h01;
   localparam logic [5:0] A_STATUS   = 6'h02;
   localparam logic [5:0] A_SPICFG   = 6'h03;
   localparam logic [5:0] A_GENCFG   = 6'h04;
   localparam logic [5:0] A_COMMONEN = 6'h05;
   localparam logic [5:0] A_SYNCEN   = 6'h06;
   localparam logic [5:0] A_PWDN     = 6'h09;
   localparam logic [5:0] A_RANGE    = 6'h0a;
   localparam logic [5:0] A_TRIGGER  = 6'h0e;
   localparam logic [5:0] A_COMMON   = 6'h0f;
   localparam logic [5:0] A_CHAN0    = 6'h10;

   // reset values
   localparam logic [15:0] RST_SPICFG   = 16'h0aa4;
   localparam logic [15:0] RST_GENCFG   = 16'h4000;
   localparam logic [3:0]  RST_COMMONEN = 4'hf;
   localparam logic [3:0]  RST_SYNCEN   = 4'h0;
   localparam logic [3:0]  RST_PWDN     = 4'hf;
   localparam logic [15:0] RST_RANGE    = 16'h0000;
   localparam logic [15:0] DEVICE_ID    = 16'h1234; // identity value is arbitrary

   // configuration field positions
   localparam int CFG_OVERTEMP_EN = 11;
   localparam int CFG_SLEEP       = 5;
   localparam int CFG_LONG_FRAME  = 4;
   localparam int CFG_SO_EN       = 2;
   localparam int CFG_EDGE_SEL    = 1;
   localparam int TRG_CLEAR       = 9;
   localparam int TRG_ALARM_CLR   = 8;
   localparam int TRG_LOAD        = 4;
   localparam logic [3:0] SOFT_RESET_CODE = 4'ha;  // hex digits of 0x1010 taken as binary
   localparam logic [15:0] SOFT_RESET_WORD = 16'h1010;
   localparam int RANGE_BIPOLAR   = 3;             // range nibble msb marks bipolar
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID  = 16'h8000;

   // one decoded frame handed to the core
   typedef struct packed {
      logic        read;
      logic [5:0]  addr;
      logic [15:0] data;
   } qdu_cmd_s;

   // clear code for one channel from its range nibble
   function automatic logic [15:0] qdu_clear_code(input logic [3:0] range);
      return range[RANGE_BIPOLAR] ? CODE_MID : CODE_ZERO;
   endfunction
endpackage

// ---- hw/qdu_sync2.sv ----
// two-flop synchroniser for a level from outside the clock domain
module qdu_sync2
   import qdu_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk_i,   // core clock
   input  wire logic rst_n_i, // synchronous reset, active low
   input  wire logic d_i,     // asynchronous level
   output logic      q_o      // synchronised level
);
   logic meta;

   // first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta <= RST_VAL;
         q_o  <= RST_VAL;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

// ---- hw/qdu_link.sv ----
// serial frame receiver and readback shifter, sampled by the core clock
module qdu_link
   import qdu_pkg::*;
(
   input  wire logic        clk_i,        // core clock
   input  wire logic        rst_n_i,      // synchronous reset, active low
   input  wire logic        sclk_s_i,     // synchronised serial clock
   input  wire logic        sel_n_s_i,    // synchronised frame strobe
   input  wire logic        din_s_i,      // synchronised serial_in
   input  wire logic        long_frame_i, // 32-bit frames
   input  wire logic        edge_sel_i,   // out_edge_select: 1 falling, 0 rising
   input  wire logic [23:0] reply_i,      // word for the next frame
   output qdu_cmd_s         cmd_o,        // decoded frame
   output logic             cmd_vld_o,    // one-cycle pulse at strobe rise
   output logic             so_o          // serial bit
);
   localparam int CHECK_BITS = FRAME_LONG - FRAME_SHORT; // trailing check bits of a long frame
   logic        sclk_d;
   logic        sel_n_d;
   logic [31:0] shreg;
   logic [5:0]  nbits;
   logic [23:0] oreg;
   logic        fall;
   logic        rise;
   logic        start;
   logic        stop;

   assign fall  = sclk_d & ~sclk_s_i;
   assign rise  = ~sclk_d & sclk_s_i;
   assign start = sel_n_d & ~sel_n_s_i;
   assign stop  = ~sel_n_d & sel_n_s_i;

   // edge history
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sclk_d  <= 1'b0;
         sel_n_d <= 1'b1;
      end else begin
         sclk_d  <= sclk_s_i;
         sel_n_d <= sel_n_s_i;
      end
   end

   // shift on falling edges only while selected; surplus bits are dropped
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || start) begin
         shreg <= 32'h0;
         nbits <= 6'h0;
      end else if (!sel_n_s_i && fall && nbits < (long_frame_i ? 6'(FRAME_LONG) : 6'(FRAME_SHORT))) begin
         shreg <= {shreg[30:0], din_s_i};
         nbits <= nbits + 6'h1;
      end
   end

   // decoded command passes on strobe rise; short frames discarded
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cmd_vld_o <= 1'b0;
         cmd_o     <= '0;
      end else begin
         cmd_vld_o <= stop && nbits >= (long_frame_i ? 6'(FRAME_LONG) : 6'(FRAME_SHORT));
         if (stop) begin
            cmd_o <= long_frame_i ? {shreg[BIT_READ + CHECK_BITS], shreg[ADDR_HI + CHECK_BITS:CHECK_BITS]}
                                  : {shreg[BIT_READ], shreg[ADDR_HI:0]};
         end
      end
   end

   // readback word loads at frame start and shifts msb first on the chosen edge
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         oreg <= 24'h0;
         so_o <= 1'b0;
      end else if (start) begin
         oreg <= {reply_i[22:0], 1'b0};
         so_o <= reply_i[23];
      end else if (!sel_n_s_i && (edge_sel_i ? fall : rise)) begin
         oreg <= {oreg[22:0], 1'b0};
         so_o <= oreg[23];
      end
   end
endmodule

// ---- dv/qdu_top_asserts.sv ----
// checker: port-level timing properties of the quad dac update block
module qdu_top_asserts #(
   parameter int POR_CYC = 50 // reinit busy time
) (
   input wire logic        clk_i,           // core clock
   input wire logic        rst_n_i,         // sync reset, active low
   input wire logic        supply_ok_i,     // supplies valid
   input wire logic        reset_pin_n_i,   // hardware reset pin
   input wire logic        sel_n_i,         // frame strobe
   input wire logic        clear_pin_n_i,   // clear pin
   input wire logic        load_pin_n_i,    // load pin
   input wire logic        overtemp_i,      // die hot
   input wire logic        serial_out_oe_o, // reply drive enable
   input wire logic [63:0] active_code_o,   // active codes
   input wire logic [3:0]  chan_on_o,       // amplifiers on
   input wire logic        busy_o           // reinit busy
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // busy length; restarts while a reset source still holds, so held resets do not look long
   int unsigned bcnt;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !busy_o || !supply_ok_i || !reset_pin_n_i) bcnt <= 0;
      else bcnt <= bcnt + 1;
   end
   property p_busy_len;
      $fell(busy_o) |-> bcnt + 2 >= POR_CYC && bcnt <= POR_CYC + 4;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("reinit time wrong");
   property p_hot;
      overtemp_i [*8] |-> chan_on_o == 4'h0;
   endproperty
   a_hot: assert property (p_hot) else $error("outputs on while hot");
   property p_oe;
      sel_n_i [*6] |-> !serial_out_oe_o;
   endproperty
   a_oe: assert property (p_oe) else $error("reply driven outside frame");
   property p_clr;
      (!clear_pin_n_i) [*6] |=> $stable(active_code_o);
   endproperty
   a_clr: assert property (p_clr) else $error("code moved during clear");
   property p_rstpin;
      $fell(reset_pin_n_i) |-> ##[1:6] (busy_o && chan_on_o == 4'h0 && active_code_o == 64'h0);
   endproperty
   a_rstpin: assert property (p_rstpin) else $error("reset pin not acted on");
   property p_supply;
      $fell(supply_ok_i) |-> ##[1:6] busy_o;
   endproperty
   a_supply: assert property (p_supply) else $error("supply drop not acted on");
   property p_busy0;
      busy_o [*2] |-> active_code_o == 64'h0 && chan_on_o == 4'h0;
   endproperty
   a_busy0: assert property (p_busy0) else $error("state not default while busy");
   // the window opens well after the previous strobe rise, so late actions of that frame are past
   sequence s_quiet;
      (!sel_n_i && load_pin_n_i && clear_pin_n_i && reset_pin_n_i && supply_ok_i) [*8];
   endsequence
   property p_quiet;
      s_quiet |-> $stable(active_code_o);
   endproperty
   a_quiet: assert property (p_quiet) else $error("code moved mid frame");
   c_busy: cover property ($fell(busy_o));
   c_oe: cover property ($rose(serial_out_oe_o));
   c_hot: cover property (overtemp_i [*8]);
endmodule
bind qdu_top qdu_top_asserts #(.POR_CYC(POR_CYC)) u_chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .supply_ok_i(supply_ok_i), .reset_pin_n_i(reset_pin_n_i),
   .sel_n_i(sel_n_i), .clear_pin_n_i(clear_pin_n_i), .load_pin_n_i(load_pin_n_i),
   .overtemp_i(overtemp_i), .serial_out_oe_o(serial_out_oe_o), .active_code_o(active_code_o),
   .chan_on_o(chan_on_o), .busy_o(busy_o));

// ---- dv/qdu_host.sv ----
// host model: drives serial frames and collects the reply word
module qdu_host (
   output logic      sclk_o,  // serial clock, stands high between frames
   output logic      sel_n_o, // frame strobe
   output logic      serial_in_o,  // serial data to block
   input  wire logic so_i     // resolved reply line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic edge1 = 1'b0; // 0: reply launched on rising edges, 1: on falling edges
   initial begin
      sclk_o = 1'b1;
      sel_n_o = 1'b1;
      serial_in_o = 1'b0;
   end
   // one frame of n bits, msb of w first; 400 ns serial period
   task automatic xfer(input logic [31:0] w, input int n, output logic [23:0] rx);
      rx = 24'h0;
      sel_n_o = 1'b0;
      #200;
      for (int i = 0; i < n; i++) begin
         serial_in_o = w[31 - i];
         #190;
         if (edge1 && i < 24) rx = {rx[22:0], so_i};
         #10;
         sclk_o = 1'b0;
         #100;
         if (!edge1 && i < 24) rx = {rx[22:0], so_i};
         #100;
         sclk_o = 1'b1;
      end
      #200;
      sel_n_o = 1'b1;
      serial_in_o = ~serial_in_o;
      #1200;
   endtask
endmodule

// ---- dv/test_qdu_top.sv ----
// testbench: frame-driven scenarios for the quad dac update block
module test_qdu_top;
   timeunit 1ns;
   timeprecision 1ns;
   import qdu_pkg::*;
   logic clk = 1'b0, rst_n, supply_ok, rst_pin_n, load_n, clr_n, hot;
   logic sclk, sel_n, serial_in, so, oe, ref_on, fault_n, busy;
   logic [63:0] code;
   logic [3:0] on;
   logic [23:0] r;
   int n_mismatch = 0, n_compared = 0, n_cyc = 0;
   // released reply line shows the inverse of its last bit
   wire so_w = oe ? so : ~so;
   qdu_host host (.sclk_o(sclk), .sel_n_o(sel_n), .serial_in_o(serial_in), .so_i(so_w));
   qdu_top #(.POR_CYC(50)) dut (
      .clk_i(clk), .rst_n_i(rst_n), .supply_ok_i(supply_ok), .reset_pin_n_i(rst_pin_n),
      .sclk_i(sclk), .sel_n_i(sel_n), .serial_in_i(serial_in), .load_pin_n_i(load_n),
      .clear_pin_n_i(clr_n), .overtemp_i(hot), .serial_out_o(so), .serial_out_oe_o(oe),
      .active_code_o(code), .chan_on_o(on), .ref_on_o(ref_on), .fault_n_o(fault_n), .busy_o(busy));
   always #25 clk = ~clk;
   // a hang ends as a mismatch
   always @(posedge clk) begin
      n_cyc++;
      if (n_cyc == 40000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      host.xfer({2'b00, a, d, 8'h00}, 24, r);
   endtask
   task automatic rd(input logic [5:0] a);
      host.xfer({2'b10, a, 24'h0}, 24, r);
      host.xfer(32'h0, 24, r);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 200 && busy !== 1'b0; i++) tick(1);
      chk(busy, 1'b0);
   endtask
   task automatic t_reset();
      chk({on, ref_on, fault_n, busy, oe}, {4'h0, 1'b0, 1'b1, 1'b1, 1'b0});
      chk(code, 64'h0);
      wait_idle();
   endtask
   task automatic t_async();
      wr(A_SPICFG, 16'h0a84);
      wr(A_PWDN, 16'h0000);
      chk({on, ref_on}, {4'hf, 1'b1});
      wr(A_CHAN0, 16'h1234);
      chk(code, 64'h1234);
   endtask
   task automatic t_sync();
      wr(A_SYNCEN, 16'h0002);
      wr(A_CHAN0 | 6'h01, 16'habcd);
      chk(code, 64'h1234);
      wr(A_TRIGGER, 16'h0010);
      chk(code, 64'habcd1234);
      wr(A_CHAN0 | 6'h01, 16'h1111);
      chk(code, 64'habcd1234);
      load_n = 1'b0;
      tick(3);
      load_n = 1'b1;
      tick(10);
      chk(code, 64'h11111234);
   endtask
   task automatic t_common();
      wr(A_COMMONEN, 16'h0007);
      wr(A_COMMON, 16'h5555);
      chk(code, 64'h0000_5555_1111_5555);
      wr(A_TRIGGER, 16'h0010);
      chk(code, 64'h0000_5555_5555_5555);
   endtask
   task automatic t_frames();
      host.xfer({2'b00, A_CHAN0 | 6'h03, 16'h7777, 8'h00}, 23, r);
      chk(code[63:48], 16'h0000);
      host.xfer({2'b00, A_CHAN0 | 6'h03, 16'h7777, 8'hff}, 30, r);
      chk(code[63:48], 16'h7777);
      wr(A_SPICFG, 16'h0a94);
      host.xfer({2'b00, A_CHAN0 | 6'h02, 16'h6666, 8'h00}, 32, r);
      chk(code[47:32], 16'h6666);
      host.xfer({2'b00, A_SPICFG, 16'h0a84, 8'h00}, 32, r);
   endtask
   task automatic t_read();
      rd(A_DEVID);
      chk(r & 24'hbfffff, {2'b10, A_DEVID, DEVICE_ID});
      wr(A_SPICFG, 16'h0a86);
      host.edge1 = 1'b1;
      rd(A_SYNCEN);
      chk(r & 24'hbfffff, {2'b10, A_SYNCEN, 16'h0002});
      host.edge1 = 1'b0;
      wr(A_SPICFG, 16'h0a84);
   endtask
   task automatic t_clear();
      clr_n = 1'b0;
      tick(8);
      clr_n = 1'b1;
      tick(8);
      chk(code, 64'h0);
      wr(A_RANGE, 16'h0008);
      wr(A_TRIGGER, 16'h0200);
      chk(code, 64'h8000);
   endtask
   task automatic t_alarm();
      hot = 1'b1;
      tick(10);
      chk({on, fault_n}, {4'h0, 1'b0});
      rd(A_STATUS);
      chk(r[0], 1'b1);
      hot = 1'b0;
      wr(A_TRIGGER, 16'h0100);
      chk({on, fault_n}, {4'h0, 1'b0});
      wr(A_SPICFG, 16'h0aa4);
      chk(ref_on, 1'b1);
      wr(A_PWDN, 16'h000f);
      wr(A_TRIGGER, 16'h0100);
      chk({fault_n, ref_on}, {1'b1, 1'b0});
      wr(A_SPICFG, 16'h0a84);
      wr(A_PWDN, 16'h0000);
      chk({on, ref_on, code[15:0]}, {4'hf, 1'b1, 16'h8000});
   endtask
   task automatic t_resets();
      wr(A_TRIGGER, SOFT_RESET_WORD);
      chk({busy, on, code}, {1'b1, 4'h0, 64'h0});
      wait_idle();
      wr(A_CHAN0, 16'h2222);
      chk(code, 64'h2222);
      rst_pin_n = 1'b0;
      tick(1);
      rst_pin_n = 1'b1;
      tick(6);
      chk({busy, code}, {1'b1, 64'h0});
      wait_idle();
      supply_ok = 1'b0;
      tick(6);
      chk(busy, 1'b1);
      supply_ok = 1'b1;
      wait_idle();
   endtask
   initial begin
      rst_n = 1'b0;
      supply_ok = 1'b1;
      rst_pin_n = 1'b1;
      load_n = 1'b1;
      clr_n = 1'b1;
      hot = 1'b0;
      tick(5);
      rst_n = 1'b1;
      t_reset();
      t_async();
      t_sync();
      t_common();
      t_frames();
      t_read();
      t_clear();
      t_alarm();
      t_resets();
      report_and_stop();
   end
endmodule
